// file: core/obd_hdr_defines.svh
// constants for the request header control block
// Behaviour
// - header bytes stay as loaded until another header load or reset
// - every transmitted request uses the currently loaded header bytes
// - auto receive, functional header: receive address is second byte plus one
// - auto receive, physical header: receive address is the third header byte
// - a receive address load overrides auto mode until reset or auto re-enabled
// - only message types 8 to 15 are accepted in the first header byte
// - timeout load takes one byte; ff gives the longest reply wait
// - replies keep being returned while each arrives before the timeout
// - stop character is discarded; current line finishes, then prompt
// - no reply before timeout gives a no-data indication
`ifndef OBD_HDR_DEFINES_SVH
`define OBD_HDR_DEFINES_SVH

// register byte offsets
`define A_HDR    8'h00
`define A_RXADDR 8'h04
`define A_TMO    8'h08
`define A_CTRL   8'h0c
`define A_REQ    8'h10
`define A_STS    8'h14
`define A_MASK   8'h18
`define A_REPLY  8'h1c

// header layout: first byte sits in bits 23:16
`define B0_LSB        16
`define HDR_TYPE_BIT  3
`define HDR_PHYS_BIT  2

// control fields
`define CTRL_AUTO 0
`define CTRL_LEN  8
`define CTRL_BUSY 16
`define REQ_MAX   3'h4

// status bits
`define ST_REPLY  0
`define ST_NODATA 1
`define ST_HDRREJ 2
`define ST_STOP   3

// reset values
`define HDR_RST 24'h68_6af1
`define RXA_RST 8'h6b
`define TMO_RST 8'h32

// timing: one timeout step in microseconds, clock in mhz
`define CLK_MHZ 125
`define TICK_US 1000

`endif

// file: core/obd_hdr_pkg.sv
// types for the request header control block
`default_nettype none
package obd_hdr_pkg;

   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} state_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       last;
   } bus_byte_t;

   typedef struct packed {
      state_t      st;
      logic [23:0] hdr;
      logic [7:0]  rxa;
      logic        auto_rx;
      logic [7:0]  tmo;
      logic [2:0]  req_len;
      logic [31:0] req;
      logic [2:0]  idx;
      logic [23:0] pre;
      logic [7:0]  tcnt;
      logic        got;
      logic        brk;
      logic [3:0]  sts;
      logic [3:0]  msk;
      logic [31:0] reply;
      logic [3:0]  ridx;
      logic        match;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        irq;
      bus_byte_t   tx;
      logic        prompt;
   } regs_t;

endpackage
`default_nettype wire

// file: core/obd_request_header_control.sv
// request header control: header/receive address/timeout, request send, reply wait
`include "obd_hdr_defines.svh"
`default_nettype none
module obd_request_header_control
   import obd_hdr_pkg::*;
#(
   parameter int unsigned TICK_CYC = `TICK_US * `CLK_MHZ
) (
   // clock, reset, enable
   input  wire logic      core_clk_i,
   input  wire logic      rstn_i,
   input  wire logic      ce_i,
   // apb slave
   input  wire apb_req_t  apb_i,
   output logic [31:0]    prdata_o,
   output logic           pready_o,
   output logic           pslverr_o,
   output logic           irq_o,
   // host serial side
   input  wire logic      host_char_i,
   output logic           prompt_o,
   // vehicle bus side
   output bus_byte_t      tx_o,
   input  wire logic      tx_ready_i,
   input  wire bus_byte_t rx_i
);

   localparam logic [23:0] PRE_LOAD = 24'(TICK_CYC - 1);

   regs_t       r;
   regs_t       n;
   logic        acc;
   logic        wr;
   logic        rd;
   logic        tick;
   logic        stop;
   logic [3:0]  set;
   logic [31:0] rdv;
   logic [2:0]  len_w;

   // receive address derived from a header
   function automatic logic [7:0] auto_rx(input logic [23:0] h);
      if (h[`B0_LSB + `HDR_PHYS_BIT]) begin
         return h[7:0];
      end
      return h[15:8] + 8'h01;
   endfunction

   // byte i of the outgoing message: header first, then request bytes msb first
   function automatic logic [7:0] msg_byte(input logic [23:0] h, input logic [31:0] q,
                                           input logic [2:0] i);
      logic [31:0] s;
      s = q << {i - 3'd3, 3'b000};
      case (i)
         3'd0:    return h[23:16];
         3'd1:    return h[15:8];
         3'd2:    return h[7:0];
         default: return s[31:24];
      endcase
   endfunction

   always_comb begin
      n     = r;
      set   = '0;
      stop  = 1'b0;
      rdv   = '0;
      acc   = apb_i.psel & apb_i.penable;
      wr    = acc & r.pready & apb_i.pwrite;
      rd    = acc & r.pready & ~apb_i.pwrite;
      tick  = (r.pre == '0);
      len_w = apb_i.pwdata[`CTRL_LEN +: 3];
      n.prompt = 1'b0;
      // answer one cycle into the access phase
      n.pready = acc & ~r.pready;
      if (acc & ~r.pready) begin
         n.pslverr = 1'b0;
         case (apb_i.paddr)
            `A_HDR:    rdv = 32'(r.hdr);
            `A_RXADDR: rdv = 32'(r.rxa);
            `A_TMO:    rdv = 32'(r.tmo);
            `A_CTRL: begin
               rdv[`CTRL_AUTO]     = r.auto_rx;
               rdv[`CTRL_LEN +: 3] = r.req_len;
               rdv[`CTRL_BUSY]     = (r.st != ST_IDLE);
            end
            `A_REQ:    rdv = r.req;
            `A_STS:    rdv = 32'(r.sts);
            `A_MASK:   rdv = 32'(r.msk);
            `A_REPLY:  rdv = r.reply;
            default:   n.pslverr = 1'b1;
         endcase
         n.prdata = rdv;
      end
      if (wr) begin
         case (apb_i.paddr)
            `A_HDR: begin
               // a type below 8 would ask for in-frame responses we never send
               if (apb_i.pwdata[`B0_LSB + `HDR_TYPE_BIT]) begin
                  n.hdr = apb_i.pwdata[23:0];
                  if (r.auto_rx) begin
                     n.rxa = auto_rx(apb_i.pwdata[23:0]);
                  end
               end else begin
                  set[`ST_HDRREJ] = 1'b1;
               end
            end
            `A_RXADDR: begin
               n.rxa     = apb_i.pwdata[7:0];
               n.auto_rx = 1'b0;
            end
            `A_TMO:    n.tmo = apb_i.pwdata[7:0];
            `A_CTRL: begin
               n.req_len = (len_w > `REQ_MAX) ? `REQ_MAX : len_w;
               n.auto_rx = apb_i.pwdata[`CTRL_AUTO];
               if (apb_i.pwdata[`CTRL_AUTO] & ~r.auto_rx) begin
                  n.rxa = auto_rx(r.hdr);
               end
            end
            `A_REQ: begin
               // a request while busy is dropped; software polls the busy bit
               if (r.st == ST_IDLE) begin
                  n.req   = apb_i.pwdata;
                  n.st    = ST_SEND;
                  n.idx   = 3'd0;
                  n.got   = 1'b0;
                  n.brk   = 1'b0;
                  n.tx    = '{valid: 1'b1, data: msg_byte(r.hdr, apb_i.pwdata, 3'd0),
                              last: 1'b0};
               end
            end
            `A_MASK:   n.msk = apb_i.pwdata[3:0];
            default: ;
         endcase
      end
      case (r.st)
         ST_SEND: begin
            if (host_char_i) begin
               n.brk = 1'b1;
            end
            if (tx_ready_i) begin
               if (r.tx.last) begin
                  n.st    = ST_WAIT;
                  n.tx    = '0;
                  n.tcnt  = r.tmo;
                  n.pre   = PRE_LOAD;
                  n.ridx  = 4'h0;
                  n.match = 1'b0;
               end else begin
                  n.idx     = r.idx + 3'd1;
                  n.tx.data = msg_byte(r.hdr, r.req, r.idx + 3'd1);
                  n.tx.last = ((r.idx + 3'd1) == (3'd2 + r.req_len));
               end
            end
         end
         ST_WAIT: begin
            n.pre = tick ? PRE_LOAD : r.pre - 24'h00_0001;
            if (rx_i.valid) begin
               if (r.ridx == 4'h1) begin
                  n.match = (rx_i.data == r.rxa);
               end
               if (r.ridx >= 4'h3 && r.match) begin
                  n.reply = {r.reply[23:0], rx_i.data};
               end
               n.ridx = (r.ridx == 4'hf) ? r.ridx : r.ridx + 4'h1;
               if (rx_i.last) begin
                  n.ridx  = 4'h0;
                  n.match = 1'b0;
                  if (r.match && r.ridx >= 4'h3) begin
                     // each reply restarts the wait, so a stream may never end
                     set[`ST_REPLY] = 1'b1;
                     n.got  = 1'b1;
                     n.tcnt = r.tmo;
                     n.pre  = PRE_LOAD;
                  end
               end
            end else if (tick) begin
               if (r.tcnt == 8'h00) begin
                  n.st     = ST_IDLE;
                  n.prompt = 1'b1;
                  set[`ST_NODATA] = ~r.got;
               end else begin
                  n.tcnt = r.tcnt - 8'h01;
               end
            end
            // the stop character is never stored; a frame in flight is finished first
            if (r.brk | host_char_i) begin
               if (r.ridx == 4'h0 || (rx_i.valid && rx_i.last)) begin
                  stop = 1'b1;
               end else begin
                  n.brk = 1'b1;
               end
            end
            if (stop) begin
               n.st     = ST_IDLE;
               n.prompt = 1'b1;
               n.brk    = 1'b0;
               n.ridx   = 4'h0;
               set[`ST_STOP] = 1'b1;
            end
         end
         default: ;
      endcase
      // a read clears only the bits it returned, so an event landing during the
      // access is kept for the next read; a new event also beats the clear
      n.sts = (r.sts & ~((rd && apb_i.paddr == `A_STS) ? r.prdata[3:0] : 4'h0)) | set;
      n.irq = |(n.sts & n.msk);
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         r <= '{st: ST_IDLE, hdr: `HDR_RST, rxa: `RXA_RST, auto_rx: 1'b1,
                tmo: `TMO_RST, default: '0};
      end else if (ce_i) begin
         r <= n;
      end
   end

   assign prdata_o  = r.prdata;
   assign pready_o  = r.pready;
   assign pslverr_o = r.pslverr;
   assign irq_o     = r.irq;
   assign prompt_o  = r.prompt;
   assign tx_o      = r.tx;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   property p_hdr_hold;
      ce_i && !(wr && apb_i.paddr == `A_HDR) |=> $stable(r.hdr);
   endproperty
   a_hdr_hold: assert property (p_hdr_hold) else $error("header changed without load");

   property p_tx_hdr;
      r.st == ST_SEND && r.idx == 3'd1 |-> r.tx.data == r.hdr[15:8];
   endproperty
   a_tx_hdr: assert property (p_tx_hdr) else $error("second sent byte not header");

   property p_auto_func;
      ce_i && wr && apb_i.paddr == `A_HDR && r.auto_rx
         && apb_i.pwdata[`B0_LSB + `HDR_TYPE_BIT]
         && !apb_i.pwdata[`B0_LSB + `HDR_PHYS_BIT]
      |=> r.rxa == $past(apb_i.pwdata[15:8]) + 8'h01;
   endproperty
   a_auto_func: assert property (p_auto_func) else $error("functional rx address wrong");

   property p_auto_phys;
      ce_i && wr && apb_i.paddr == `A_HDR && r.auto_rx
         && apb_i.pwdata[`B0_LSB + `HDR_TYPE_BIT]
         && apb_i.pwdata[`B0_LSB + `HDR_PHYS_BIT]
      |=> r.rxa == $past(apb_i.pwdata[7:0]);
   endproperty
   a_auto_phys: assert property (p_auto_phys) else $error("physical rx address wrong");

   property p_man_hold;
      ce_i && !r.auto_rx && !(wr && (apb_i.paddr == `A_RXADDR || apb_i.paddr == `A_CTRL))
      |=> $stable(r.rxa) && !r.auto_rx;
   endproperty
   a_man_hold: assert property (p_man_hold) else $error("manual rx address lost");

   property p_type;
      r.hdr[`B0_LSB + `HDR_TYPE_BIT];
   endproperty
   a_type: assert property (p_type) else $error("header type below 8");

   property p_tmo;
      ce_i && wr && apb_i.paddr == `A_TMO |=> r.tmo == $past(apb_i.pwdata[7:0]);
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout not loaded");

   property p_reload;
      ce_i && set[`ST_REPLY] && !stop && !(wr && apb_i.paddr == `A_TMO)
      |=> r.tcnt == r.tmo && r.sts[`ST_REPLY] && r.st == ST_WAIT;
   endproperty
   a_reload: assert property (p_reload) else $error("reply did not restart wait");

   property p_nodata;
      ce_i && r.st == ST_WAIT && tick && r.tcnt == 8'h00 && !r.got && !rx_i.valid
         && !host_char_i && !r.brk
      |=> r.st == ST_IDLE && r.sts[`ST_NODATA] && r.prompt;
   endproperty
   a_nodata: assert property (p_nodata) else $error("no-data not flagged");

   property p_stop;
      ce_i && r.st == ST_WAIT && host_char_i && r.ridx == 4'h0
      |=> r.st == ST_IDLE && r.prompt && r.sts[`ST_STOP];
   endproperty
   a_stop: assert property (p_stop) else $error("stop character not honoured");

   property p_accept;
      set[`ST_REPLY] |-> r.match && r.st == ST_WAIT;
   endproperty
   a_accept: assert property (p_accept) else $error("reply for other address taken");

   property p_match;
      ce_i && r.st == ST_WAIT && rx_i.valid && !rx_i.last && r.ridx == 4'h1
      |=> r.match == ($past(rx_i.data) == $past(r.rxa));
   endproperty
   a_match: assert property (p_match) else $error("destination compare wrong");

   property p_last;
      ce_i && r.st == ST_SEND && tx_ready_i && r.tx.last |=> r.st == ST_WAIT && !r.tx.valid;
   endproperty
   a_last: assert property (p_last) else $error("message did not end on last byte");

endmodule
`default_nettype wire

// file: test/obd_request_header_control_bench.sv
// self-checking bench for the request header control block
`include "obd_hdr_defines.svh"
`default_nettype none
module obd_request_header_control_bench;
   import obd_hdr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_i;
   logic        rstn_i;
   apb_req_t    apb_i;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        irq_o;
   logic        host_char_i;
   logic        prompt_o;
   bus_byte_t   tx_o;
   logic        tx_ready_i;
   bus_byte_t   rx_i;
   int          errors;
   int          total_checks;
   int          n;
   int          k;
   int          lens[3] = '{0, 2, 5};
   logic [31:0] rd;
   logic        er;
   logic [31:0] hdr_m;
   logic [7:0]  rxa_m;
   logic        auto_m;
   logic [31:0] req;

   // short timeout tick keeps the reply waits to a few dozen cycles
   obd_request_header_control #(.TICK_CYC(4)) obd_request_header_control_inst (
      .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .apb_i(apb_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
      .host_char_i(host_char_i), .prompt_o(prompt_o), .tx_o(tx_o),
      .tx_ready_i(tx_ready_i), .rx_i(rx_i));
   vehicle_bus_model veh (
      .core_clk_i(core_clk_i), .tx_i(tx_o), .tx_ready_o(tx_ready_i), .rx_o(rx_i));

   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end

   task automatic test_done();
      if (errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hang();
      errors++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      test_done();
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int c;
      @(posedge core_clk_i);
      apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge core_clk_i);
      apb_i.penable <= 1'b1;
      c = 0;
      do begin
         @(posedge core_clk_i);
         c++;
      end while (pready_o !== 1'b1 && c < 20);
      if (c >= 20) hang();
      rd = prdata_o;
      er = pslverr_o;
      apb_i <= '0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask

   // model follows header loads; receive address derived only in auto mode
   task automatic set_hdr(input logic [23:0] h);
      apb(1'b1, `A_HDR, {8'h00, h});
      if (h[`B0_LSB + `HDR_TYPE_BIT]) begin
         hdr_m = {8'h00, h};
         if (auto_m) begin
            rxa_m = h[`B0_LSB + `HDR_PHYS_BIT] ? h[7:0] : h[15:8] + 8'h01;
         end
      end
   endtask

   initial begin
      errors = 0;
      total_checks = 0;
      rstn_i = 1'b0;
      host_char_i = 1'b0;
      apb_i = '0;
      hdr_m = 32'h0068_6af1;
      rxa_m = 8'h6b;
      auto_m = 1'b1;
      void'($urandom(74));
      repeat (10) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      rchk(`A_HDR, hdr_m);
      rchk(`A_RXADDR, 32'h0000_006b);
      rchk(`A_TMO, 32'h0000_0032);
      rchk(`A_MASK, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({rd[30:0], er}, 32'h0000_0001);
      apb(1'b1, `A_MASK, 32'h0000_000f);
      set_hdr(24'h61_48f1);
      rchk(`A_HDR, hdr_m);
      chk(32'(irq_o), 32'h0000_0001);
      rchk(`A_STS, 32'h0000_0004);
      set_hdr(24'ha8_48f1);
      rchk(`A_RXADDR, 32'(rxa_m));
      rchk(`A_HDR, hdr_m);
      set_hdr(24'hec_10f1);
      rchk(`A_RXADDR, 32'(rxa_m));
      apb(1'b1, `A_RXADDR, 32'h0000_006b);
      auto_m = 1'b0;
      rxa_m = 8'h6b;
      set_hdr(24'ha8_48f1);
      rchk(`A_RXADDR, 32'h0000_006b);
      apb(1'b1, `A_CTRL, 32'h0000_0000);
      apb(1'b1, `A_CTRL, 32'h0000_0001);
      auto_m = 1'b1;
      rxa_m = hdr_m[`B0_LSB + `HDR_PHYS_BIT] ? hdr_m[7:0] : hdr_m[15:8] + 8'h01;
      rchk(`A_RXADDR, 32'(rxa_m));
      apb(1'b1, `A_TMO, 32'h0000_00ff);
      rchk(`A_TMO, 32'h0000_00ff);
      apb(1'b1, `A_TMO, 32'h0000_0008);
      for (int i = 0; i < 3; i++) begin
         n = (lens[i] > 4) ? 4 : lens[i];
         req = $urandom();
         veh.got_q.delete();
         apb(1'b1, `A_CTRL, 32'(lens[i] << 8) | 32'h0000_0001);
         apb(1'b1, `A_REQ, req);
         k = 0;
         while (veh.got_q.size() < 3 + n && k < 200) begin
            @(posedge core_clk_i);
            k++;
         end
         if (k >= 200) hang();
         for (int j = 0; j < 3 + n; j++) begin
            chk(32'(veh.got_q[j]), 32'({1'(j == n + 2), (j < 3) ? hdr_m[23 - 8 * j -: 8]
               : req[31 - 8 * (j - 3) -: 8]}));
         end
         if (i == 1) begin
            veh.send('{8'h48, rxa_m, 8'h10, 8'h11, 8'h22, 8'h33, 8'h44});
            apb(1'b0, `A_CTRL, 32'h0000_0000);
            chk(32'(rd[`CTRL_BUSY]), 32'h0000_0001);
            veh.send('{8'h48, rxa_m, 8'h10, 8'h55, 8'h66, 8'h77, 8'h88});
            veh.send('{8'h48, 8'h77, 8'h10, 8'h01, 8'h02, 8'h03, 8'h04});
            host_char_i <= 1'b1;
            @(posedge core_clk_i);
            host_char_i <= 1'b0;
         end
         k = 0;
         do begin
            @(posedge core_clk_i);
            k++;
         end while (prompt_o !== 1'b1 && k < 2000);
         if (k >= 2000) hang();
         repeat (2) @(posedge core_clk_i);
         chk(32'(irq_o), 32'h0000_0001);
         rchk(`A_STS, (i == 1) ? 32'h0000_0009 : 32'h0000_0002);
         if (i == 1) rchk(`A_REPLY, 32'h5566_7788);
         repeat (2) @(posedge core_clk_i);
         chk(32'(irq_o), 32'h0000_0000);
      end
      test_done();
   end
endmodule
`default_nettype wire

// file: test/vehicle_bus_model.sv
// vehicle bus partner: takes request bytes with stalls, plays reply frames
`default_nettype none
module vehicle_bus_model
   import obd_hdr_pkg::*;
(
   // clock
   input  wire logic      core_clk_i,
   // request bytes from the block
   input  wire bus_byte_t tx_i,
   output logic           tx_ready_o,
   // reply bytes to the block
   output bus_byte_t      rx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] got_q[$];
   initial begin
      tx_ready_o = 1'b0;
      rx_o       = '0;
   end
   // random stalls, so the block must hold valid, data and last until taken
   always @(posedge core_clk_i) begin
      if (tx_i.valid && tx_ready_o) got_q.push_back({tx_i.last, tx_i.data});
      tx_ready_o <= 1'($urandom_range(0, 1));
   end
   // one byte per cycle, last on the final one; idle data flips so stale bytes show
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         @(posedge core_clk_i);
         rx_o <= '{valid: 1'b1, data: b[i], last: 1'(i == b.size() - 1)};
      end
      @(posedge core_clk_i);
      rx_o <= '{valid: 1'b0, data: ~b[b.size() - 1], last: 1'b0};
   endtask
endmodule
`default_nettype wire
